// >>> rtl/rcs_core.sv
// command state machine with apb registers, fifo and internal buffer
//
// The implementer's own choices: register access over APB and the register offsets.
`timescale 1ns/100ps
module rcs_core import rcs_pkg::*; #(
	parameter int FIFO_DEPTH = 64
) (
	// clock and control
	input wire logic clk_i,
	input wire logic srst_i,
	input wire logic hard_pd_rst_i,
	input wire logic ce_i,
	// apb slave
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [7:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	// rf datapath
	output rcs_byte_t tx_byte_o,
	input wire logic tx_ready_i,
	input wire rcs_byte_t rx_byte_i,
	input wire logic rx_end_i,
	output logic rx_enable_o,
	output logic receiver_off_o,
	output logic power_down_o,
	// authentication engine
	output logic auth_start_o,
	output logic [7:0] auth_arg_o,
	output logic auth_arg_valid_o,
	input wire logic auth_done_i,
	input wire logic auth_error_i,
	// irq events
	output logic rx_irq_o,
	output logic tx_irq_o,
	output logic idle_irq_o
);
	localparam int PW = $clog2(FIFO_DEPTH + 1);
	localparam int AW = $clog2(FIFO_DEPTH);

	rcs_state_t state_q;
	logic [7:0] fifo_mem [FIFO_DEPTH];
	logic [7:0] buf_mem [BUF_BYTES];
	logic [AW-1:0] rd_q, wr_q;
	logic [PW-1:0] level_q;
	logic [3:0] cmd_q;
	logic rcv_off_q, pwr_down_q, start_send_q, multi_q, wr_err_q, prot_err_q, cipher_q;
	logic [7:0] mode_q, test_q, speed_q;
	logic [15:0] crc_q, lfsr_q;
	logic [4:0] cnt_q;
	logic tx_irq_q, rx_irq_q, idle_irq_q;

	wire apb_wr = psel_i && penable_i && pwrite_i;
	wire apb_rd = psel_i && penable_i && !pwrite_i;
	wire cmd_wr = ce_i && apb_wr && paddr_i == ADDR_CMD;
	wire [3:0] new_cmd = pwdata_i[3:0];
	wire soft_rst = cmd_wr && new_cmd == CMD_SOFT_RESET;
	wire regs_rst = srst_i || soft_rst;
	wire fifo_empty = level_q == '0;
	wire fifo_full = level_q == PW'(FIFO_DEPTH);
	wire auth_busy = state_q == ST_AUTH_ARG || state_q == ST_AUTH_RUN;
	wire fifo_host = ce_i && psel_i && penable_i && paddr_i == ADDR_FIFO;
	wire host_push = fifo_host && pwrite_i && !auth_busy && !fifo_full;
	wire host_pop = fifo_host && !pwrite_i && !auth_busy && !fifo_empty;
	wire new_start = cmd_wr && new_cmd != CMD_KEEP;

	// internal pushes and pops per state
	logic int_pop, int_push;
	logic [7:0] int_data;
	always_comb begin
		int_pop = 1'b0;
		int_push = 1'b0;
		int_data = 8'h00;
		if (ce_i && !new_start) begin
			case (state_q)
				ST_MEM_IN, ST_CRC, ST_AUTH_ARG: int_pop = !fifo_empty;
				ST_TX: int_pop = !fifo_empty && tx_ready_i;
				ST_MEM_OUT: begin
					int_push = !fifo_full;
					int_data = buf_mem[cnt_q];
				end
				ST_SELF: begin
					int_push = !fifo_full && cnt_q < 5'(SELF_TEST_BYTES);
					int_data = cnt_q[0] ? crc_q[15:8] : crc_q[7:0];
				end
				ST_RX: begin
					int_push = rx_byte_i.valid && !fifo_full;
					int_data = rx_byte_i.data;
				end
				default: ;
			endcase
		end
	end
	wire do_pop = host_pop || int_pop;
	wire do_push = host_push || int_push;

	// fifo storage; cleared by srst_i or the soft reset command, never when any other command starts
	always_ff @(posedge clk_i) begin
		if (regs_rst) begin
			rd_q <= '0;
			wr_q <= '0;
			level_q <= '0;
		end else if (ce_i) begin
			if (do_push) begin
				fifo_mem[wr_q] <= host_push ? pwdata_i[7:0] : int_data;
				wr_q <= wr_q == AW'(FIFO_DEPTH - 1) ? '0 : wr_q + 1'b1;
			end
			if (do_pop)
				rd_q <= rd_q == AW'(FIFO_DEPTH - 1) ? '0 : rd_q + 1'b1;
			level_q <= level_q + PW'(do_push) - PW'(do_pop);
		end
	end
	wire [7:0] fifo_head = fifo_mem[rd_q];

	// internal buffer: no reset of any kind touches it
	always_ff @(posedge clk_i) begin
		if (ce_i && int_pop && state_q == ST_MEM_IN && !new_start)
			buf_mem[cnt_q] <= fifo_head;
		if (ce_i && state_q == ST_RAND)
			buf_mem[cnt_q] <= lfsr_q[7:0];
	end

	// free running random source
	always_ff @(posedge clk_i) begin
		if (srst_i)
			lfsr_q <= LFSR_SEED;
		else if (ce_i)
			lfsr_q <= {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
	end

	// command state machine
	always_ff @(posedge clk_i) begin
		if (regs_rst) begin
			state_q <= ST_IDLE;
			cnt_q <= '0;
			cmd_q <= CMD_IDLE;
		end else if (ce_i) begin
			if (new_start) begin
				cmd_q <= new_cmd;
				cnt_q <= '0;
				case (new_cmd)
					CMD_IDLE: state_q <= ST_IDLE;
					CMD_MEM: state_q <= fifo_empty ? ST_MEM_OUT : ST_MEM_IN;
					CMD_RANDOM_ID: state_q <= ST_RAND;
					CMD_CRC_CALC:
						state_q <= test_q[3:0] == SELF_TEST_ON ? ST_SELF : ST_CRC;
					CMD_TRANSMIT: state_q <= ST_TX;
					CMD_RECEIVE: state_q <= ST_RX;
					CMD_TRANSCEIVE: state_q <= ST_TRX_WAIT;
					CMD_CARD_AUTH: state_q <= ST_AUTH_ARG;
					default: state_q <= ST_IDLE;
				endcase
			end else begin
				case (state_q)
					ST_MEM_IN: if (int_pop) begin
						cnt_q <= cnt_q + 1'b1;
						if (cnt_q == 5'(BUF_BYTES - 1)) begin
							state_q <= ST_IDLE;
							cmd_q <= CMD_IDLE;
						end
					end
					ST_MEM_OUT: if (int_push) begin
						cnt_q <= cnt_q + 1'b1;
						if (cnt_q == 5'(BUF_BYTES - 1)) begin
							state_q <= ST_IDLE;
							cmd_q <= CMD_IDLE;
						end
					end
					ST_RAND: begin
						cnt_q <= cnt_q + 1'b1;
						if (cnt_q == 5'(RAND_BYTES - 1)) begin
							state_q <= ST_IDLE;
							cmd_q <= CMD_IDLE;
						end
					end
					ST_SELF: if (int_push) begin
						cnt_q <= cnt_q + 1'b1;
						// no crc drain here, or the result would be eaten
					end
					ST_TX: if (fifo_empty) begin
						if (cmd_q == CMD_TRANSCEIVE) begin
							state_q <= ST_RX;
						end else begin
							state_q <= ST_IDLE;
							cmd_q <= CMD_IDLE;
						end
					end
					ST_TRX_WAIT: if (start_send_q)
						state_q <= ST_TX;
					ST_RX: if (rx_end_i && !multi_q) begin
						if (cmd_q == CMD_TRANSCEIVE) begin
							state_q <= ST_TRX_WAIT;
						end else begin
							state_q <= ST_IDLE;
							cmd_q <= CMD_IDLE;
						end
					end
					ST_AUTH_ARG: if (int_pop) begin
						cnt_q <= cnt_q + 1'b1;
						if (cnt_q == 5'(AUTH_ARGS - 1))
							state_q <= ST_AUTH_RUN;
					end
					ST_AUTH_RUN: if (auth_done_i || auth_error_i) begin
						state_q <= ST_IDLE;
						cmd_q <= CMD_IDLE;
					end
					default: ;
				endcase
			end
		end
	end

	// crc unit, ccitt polynomial, preset from mode register
	function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] d);
		logic [15:0] r;
		r = c;
		for (int i = 0; i < 8; i++)
			r = (r[0] ^ d[i]) ? ((r >> 1) ^ 16'h8408) : (r >> 1);
		return r;
	endfunction
	always_ff @(posedge clk_i) begin
		if (regs_rst)
			crc_q <= '0;
		else if (ce_i) begin
			if (new_start && new_cmd == CMD_CRC_CALC) begin
				case (mode_q[1:0])
					2'b00: crc_q <= 16'h0000;
					2'b01: crc_q <= 16'h6363;
					2'b10: crc_q <= 16'hA671;
					default: crc_q <= 16'hFFFF;
				endcase
			end else if (int_pop && state_q == ST_CRC)
				crc_q <= crc_step(crc_q, fifo_head);
		end
	end

	// control registers
	always_ff @(posedge clk_i) begin
		if (regs_rst) begin
			rcv_off_q <= 1'b0;
			pwr_down_q <= 1'b0;
			start_send_q <= 1'b0;
			multi_q <= 1'b0;
			mode_q <= MODE_RESET;
			test_q <= '0;
			speed_q <= SPEED_RESET;
		end else if (ce_i) begin
			if (cmd_wr) begin
				rcv_off_q <= pwdata_i[CMD_RCV_OFF_BIT];
				pwr_down_q <= pwdata_i[CMD_PWR_DOWN_BIT];
			end
			if (apb_wr && paddr_i == ADDR_FRAMING)
				start_send_q <= pwdata_i[FRAMING_START_SEND_BIT];
			else if (state_q == ST_TRX_WAIT && start_send_q)
				start_send_q <= 1'b0; // consumed by one send
			if (apb_wr && paddr_i == ADDR_RXMODE)
				multi_q <= pwdata_i[RXMODE_MULTI_BIT];
			if (apb_wr && paddr_i == ADDR_MODE)
				mode_q <= pwdata_i[7:0];
			if (apb_wr && paddr_i == ADDR_TEST)
				test_q <= pwdata_i[7:0];
			if (apb_wr && paddr_i == ADDR_SPEED)
				speed_q <= pwdata_i[7:0];
		end
	end

	// error and status flags; hardware set wins over software clear
	wire auth_fifo_hit = fifo_host && auth_busy;
	wire err_clr = ce_i && apb_wr && paddr_i == ADDR_ERROR;
	wire auth_fail = ce_i && state_q == ST_AUTH_RUN && auth_error_i && !new_start;
	wire auth_ok = ce_i && state_q == ST_AUTH_RUN && auth_done_i && !new_start;
	always_ff @(posedge clk_i) begin
		if (regs_rst) begin
			wr_err_q <= 1'b0;
			prot_err_q <= 1'b0;
			cipher_q <= 1'b0;
		end else if (ce_i) begin
			if (auth_fifo_hit)
				wr_err_q <= 1'b1;
			else if (err_clr && pwdata_i[ERR_WRITE_BIT])
				wr_err_q <= 1'b0;
			if (auth_fail)
				prot_err_q <= 1'b1;
			else if (err_clr && pwdata_i[ERR_PROTOCOL_BIT])
				prot_err_q <= 1'b0;
			if (auth_fail)
				cipher_q <= 1'b0;
			else if (auth_ok)
				cipher_q <= 1'b1;
			else if (apb_wr && paddr_i == ADDR_STATUS && !pwdata_i[STATUS_CIPHER_BIT])
				cipher_q <= 1'b0;
		end
	end

	// irq event pulses; rx and tx blocked while authenticating
	always_ff @(posedge clk_i) begin
		if (regs_rst) begin
			tx_irq_q <= 1'b0;
			rx_irq_q <= 1'b0;
			idle_irq_q <= 1'b0;
		end else if (ce_i) begin
			tx_irq_q <= !auth_busy && state_q == ST_TX && fifo_empty && !new_start;
			rx_irq_q <= !auth_busy && state_q == ST_RX && rx_end_i && !new_start;
			idle_irq_q <= state_q != ST_IDLE && cmd_q != CMD_IDLE && !new_start
				&& ((state_q == ST_RX && rx_end_i && !multi_q && cmd_q == CMD_RECEIVE)
				|| auth_ok || auth_fail || (state_q == ST_TX && fifo_empty
				&& cmd_q == CMD_TRANSMIT));
		end
	end

	// apb read mux, zero wait state
	always_comb begin
		prdata_o = 32'h0000_0000;
		pslverr_o = 1'b0;
		case (paddr_i)
			ADDR_CMD: prdata_o[7:0] = {2'b00, rcv_off_q, pwr_down_q, cmd_q};
			ADDR_FIFO: prdata_o[7:0] = auth_busy ? 8'h00 : fifo_head;
			ADDR_LEVEL: prdata_o[PW-1:0] = level_q;
			ADDR_FRAMING: prdata_o[FRAMING_START_SEND_BIT] = start_send_q;
			ADDR_MODE: prdata_o[7:0] = mode_q;
			ADDR_RXMODE: prdata_o[RXMODE_MULTI_BIT] = multi_q;
			ADDR_TEST: prdata_o[7:0] = test_q;
			ADDR_ERROR: begin
				prdata_o[ERR_WRITE_BIT] = wr_err_q;
				prdata_o[ERR_PROTOCOL_BIT] = prot_err_q;
			end
			ADDR_STATUS: prdata_o[STATUS_CIPHER_BIT] = cipher_q;
			ADDR_CRC: prdata_o[15:0] = crc_q;
			ADDR_SPEED: prdata_o[7:0] = speed_q;
			ADDR_ID: prdata_o[7:0] = ID_VALUE;
			default: pslverr_o = psel_i && penable_i;
		endcase
		if (!apb_rd)
			prdata_o = 32'h0000_0000;
	end
	assign pready_o = 1'b1;

	// datapath outputs
	assign tx_byte_o.valid = state_q == ST_TX && !fifo_empty && ce_i;
	assign tx_byte_o.data = fifo_head;
	assign rx_enable_o = state_q == ST_RX && !rcv_off_q;
	assign receiver_off_o = rcv_off_q;
	assign power_down_o = pwr_down_q;
	assign auth_arg_o = fifo_head;
	assign auth_arg_valid_o = state_q == ST_AUTH_ARG && int_pop;
	assign auth_start_o = state_q == ST_AUTH_ARG && int_pop && cnt_q == 5'(AUTH_ARGS - 1);
	assign rx_irq_o = rx_irq_q;
	assign tx_irq_o = tx_irq_q;
	assign idle_irq_o = idle_irq_q;
	wire unused_hard = hard_pd_rst_i; // buffer deliberately ignores hard reset
endmodule

// >>> rtl/rcs_pkg.sv
// package for the reader command state machine
package rcs_pkg;
	// register byte addresses (own map, one 32-bit word each)
	localparam logic [7:0] ADDR_CMD = 8'h00;
	localparam logic [7:0] ADDR_FIFO = 8'h04;
	localparam logic [7:0] ADDR_LEVEL = 8'h08;
	localparam logic [7:0] ADDR_FRAMING = 8'h0C;
	localparam logic [7:0] ADDR_MODE = 8'h10;
	localparam logic [7:0] ADDR_RXMODE = 8'h14;
	localparam logic [7:0] ADDR_TEST = 8'h18;
	localparam logic [7:0] ADDR_ERROR = 8'h1C;
	localparam logic [7:0] ADDR_STATUS = 8'h20;
	localparam logic [7:0] ADDR_CRC = 8'h24;
	localparam logic [7:0] ADDR_SPEED = 8'h28;
	localparam logic [7:0] ADDR_ID = 8'h2C;
	// command codes
	localparam logic [3:0] CMD_IDLE = 4'h0;
	localparam logic [3:0] CMD_MEM = 4'h1;
	localparam logic [3:0] CMD_RANDOM_ID = 4'h2;
	localparam logic [3:0] CMD_CRC_CALC = 4'h3;
	localparam logic [3:0] CMD_TRANSMIT = 4'h4;
	localparam logic [3:0] CMD_KEEP = 4'h7;
	localparam logic [3:0] CMD_RECEIVE = 4'h8;
	localparam logic [3:0] CMD_TRANSCEIVE = 4'hC;
	localparam logic [3:0] CMD_CARD_AUTH = 4'hE;
	localparam logic [3:0] CMD_SOFT_RESET = 4'hF;
	// field positions
	localparam int CMD_RCV_OFF_BIT = 5;
	localparam int CMD_PWR_DOWN_BIT = 4;
	localparam int FRAMING_START_SEND_BIT = 7;
	localparam int RXMODE_MULTI_BIT = 2;
	localparam int ERR_WRITE_BIT = 7;
	localparam int ERR_PROTOCOL_BIT = 0;
	localparam int STATUS_CIPHER_BIT = 3;
	// reset values
	localparam logic [7:0] MODE_RESET = 8'h3F;
	localparam logic [7:0] SPEED_RESET = 8'hEB; // 9.6 kBd host rate
	localparam logic [3:0] SELF_TEST_ON = 4'h9;
	localparam logic [15:0] LFSR_SEED = 16'hACE1;
	// sizes
	localparam int BUF_BYTES = 25;
	localparam int RAND_BYTES = 10;
	localparam int AUTH_ARGS = 12;
	localparam int SELF_TEST_BYTES = 4;
	localparam logic [7:0] ID_VALUE = 8'h5A; // arbitrary identity value
	// fifo port to the surrounding datapath
	typedef struct packed {
		logic valid;
		logic [7:0] data;
	} rcs_byte_t;
	typedef enum logic [3:0] {
		ST_IDLE = 4'b0000,
		ST_MEM_IN = 4'b0001,
		ST_MEM_OUT = 4'b0011,
		ST_RAND = 4'b0010,
		ST_CRC = 4'b0110,
		ST_SELF = 4'b0111,
		ST_TX = 4'b0101,
		ST_RX = 4'b0100,
		ST_TRX_WAIT = 4'b1100,
		ST_AUTH_ARG = 4'b1101,
		ST_AUTH_RUN = 4'b1111
	} rcs_state_t;
endpackage

// >>> sim/rcs_core_properties.sv
// port assertions for the command state machine
`timescale 1ns/100ps
module rcs_core_properties import rcs_pkg::*; (
	// clock and reset
	input wire logic clk_i,
	input wire logic srst_i,
	input wire logic ce_i,
	// apb
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [7:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	input wire logic pready_o,
	// datapath
	input wire rcs_byte_t tx_byte_o,
	input wire logic tx_ready_i,
	input wire logic rx_enable_o,
	input wire logic power_down_o,
	input wire logic auth_start_o,
	input wire logic auth_arg_valid_o,
	input wire logic rx_irq_o,
	input wire logic tx_irq_o
);
	logic acc;
	logic cmd_wr;
	logic [4:0] arg_cnt_q;
	assign acc = psel_i && penable_i && ce_i;
	assign cmd_wr = acc && pwrite_i && paddr_i == ADDR_CMD;
	// argument bytes since the last command write
	always_ff @(posedge clk_i) begin
		if (srst_i || cmd_wr) begin
			arg_cnt_q <= 5'h00;
		end else if (auth_arg_valid_o) begin
			arg_cnt_q <= arg_cnt_q + 5'h01;
		end
	end
	default clocking @(posedge clk_i); endclocking
	default disable iff (srst_i);
	zero_wait_a: assert property (acc |-> pready_o)
		else $error("access not answered");
	idle_stop_a: assert property (cmd_wr && pwdata_i[3:0] == CMD_IDLE |=>
		!tx_byte_o.valid && !rx_enable_o) else $error("idle did not cancel");
	rx_start_a: assert property (cmd_wr && pwdata_i[3:0] == CMD_RECEIVE &&
		!pwdata_i[CMD_RCV_OFF_BIT] |=> rx_enable_o) else $error("receive not enabled");
	trx_hold_a: assert property (cmd_wr && pwdata_i[3:0] == CMD_TRANSCEIVE |=>
		!tx_byte_o.valid [*2]) else $error("sent before start bit");
	tx_stable_a: assert property (tx_byte_o.valid && !tx_ready_i && !acc |=>
		tx_byte_o.valid && $stable(tx_byte_o.data)) else $error("tx byte dropped");
	pd_keep_a: assert property (cmd_wr && pwdata_i[3:0] == CMD_KEEP |=>
		power_down_o == $past(pwdata_i[CMD_PWR_DOWN_BIT])) else $error("bit not updated");
	auth_args_a: assert property (auth_start_o |->
		auth_arg_valid_o && arg_cnt_q == 5'(AUTH_ARGS - 1)) else $error("auth start count");
	auth_irq_a: assert property (auth_start_o |=>
		(!rx_irq_o && !tx_irq_o) [*4]) else $error("irq during auth");
	cover property (auth_start_o);
	cover property (tx_byte_o.valid && tx_ready_i);
	cover property ($rose(rx_enable_o));
endmodule
bind rcs_core rcs_core_properties u_rcs_core_properties (
	.clk_i(clk_i), .srst_i(srst_i), .ce_i(ce_i), .psel_i(psel_i),
	.penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
	.pwdata_i(pwdata_i), .pready_o(pready_o), .tx_byte_o(tx_byte_o),
	.tx_ready_i(tx_ready_i), .rx_enable_o(rx_enable_o), .power_down_o(power_down_o),
	.auth_start_o(auth_start_o), .auth_arg_valid_o(auth_arg_valid_o),
	.rx_irq_o(rx_irq_o), .tx_irq_o(tx_irq_o)
);

// >>> sim/rcs_far_model.sv
// far-side model: rf link and authentication engine
`timescale 1ns/100ps
module rcs_far_model import rcs_pkg::*; (
	// clock
	input wire logic clk_i,
	// rf datapath
	input wire rcs_byte_t tx_byte_i,
	output logic tx_ready_o,
	output rcs_byte_t rx_byte_o,
	output logic rx_end_o,
	// authentication engine
	input wire logic auth_start_i,
	output logic auth_done_o,
	output logic auth_error_o
);
	logic [7:0] got[$];
	logic fail = 1'b0;
	int wait_n = -1;
	initial begin
		tx_ready_o = 1'b0;
		rx_byte_o = 9'h0FF;
		rx_end_o = 1'b0;
	end
	// slow taker: ready every other cycle
	always @(posedge clk_i) begin
		if (tx_byte_i.valid && tx_ready_o) got.push_back(tx_byte_i.data);
		tx_ready_o <= ~tx_ready_o;
	end
	// card answers some cycles after the start pulse
	always @(posedge clk_i) begin
		auth_done_o <= 1'b0;
		auth_error_o <= 1'b0;
		if (auth_start_i) wait_n <= 20;
		else if (wait_n > 0) wait_n <= wait_n - 1;
		else if (wait_n == 0) begin
			wait_n <= -1;
			auth_done_o <= !fail;
			auth_error_o <= fail;
		end
	end
	// one byte, then idle line shows the inverse so stale data never looks valid
	task automatic send(input logic [7:0] b, input logic last_b);
		@(posedge clk_i);
		rx_byte_o <= {1'b1, b};
		@(posedge clk_i);
		rx_byte_o <= {1'b0, ~b};
		rx_end_o <= last_b;
		@(posedge clk_i);
		rx_end_o <= 1'b0;
	endtask
endmodule

// >>> sim/test_rcs_core.sv
// testbench for the command state machine
`timescale 1ns/100ps
module test_rcs_core import rcs_pkg::*;;
	typedef struct {logic [7:0] a; logic [31:0] v; logic e;} rcs_row_t;
	logic clk_i = 0, srst_i = 1, hpd = 0, ce = 1, psel_i = 0, penable_i = 0, pwrite_i = 0;
	logic [7:0] paddr_i = 0;
	logic [31:0] pwdata_i = 0, prdata_o, rd_q;
	logic pready_o, pslverr_o, err_q, tx_rdy, rx_end, done, aerr, rx_en, pd, ast, roff, idl;
	rcs_byte_t tx_b, rx_b;
	logic [7:0] buf_q [BUF_BYTES];
	logic [15:0] pre [4] = '{16'h0000, 16'h6363, 16'hA671, 16'hFFFF};
	int n_fail = 0, tests_run = 0, cyc = 0, n_idle = 0;
	rcs_row_t rows [8] = '{'{ADDR_CMD, 0, 0}, '{ADDR_LEVEL, 0, 0}, '{ADDR_MODE, MODE_RESET, 0},
		'{ADDR_ERROR, 0, 0}, '{ADDR_STATUS, 0, 0}, '{ADDR_SPEED, SPEED_RESET, 0},
		'{ADDR_ID, ID_VALUE, 0}, '{8'h30, 0, 1}};
	rcs_core u_rcs_core (.clk_i(clk_i), .srst_i(srst_i), .hard_pd_rst_i(hpd), .ce_i(ce),
		.psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
		.pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
		.pslverr_o(pslverr_o), .tx_byte_o(tx_b), .tx_ready_i(tx_rdy), .rx_byte_i(rx_b),
		.rx_end_i(rx_end), .rx_enable_o(rx_en), .receiver_off_o(roff), .power_down_o(pd),
		.auth_start_o(ast), .auth_arg_o(), .auth_arg_valid_o(), .auth_done_i(done),
		.auth_error_i(aerr), .rx_irq_o(), .tx_irq_o(), .idle_irq_o(idl));
	rcs_far_model u_rcs_far_model (.clk_i(clk_i), .tx_byte_i(tx_b), .tx_ready_o(tx_rdy),
		.rx_byte_o(rx_b), .rx_end_o(rx_end), .auth_start_i(ast), .auth_done_o(done),
		.auth_error_o(aerr));
	initial begin
		forever #5 clk_i = ~clk_i;
	end
	task automatic conclude;
		if (n_fail == 0 && tests_run > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	// hangs end here
	always @(posedge clk_i) begin
		cyc++;
		if (cyc == 20000) begin
			n_fail++;
			conclude();
		end
	end
	// idle event pulses seen so far
	always @(posedge clk_i) begin
		if (idl === 1'b1) n_idle++;
	end
	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		psel_i <= 1'b1;
		penable_i <= 1'b0;
		pwrite_i <= w;
		paddr_i <= a;
		pwdata_i <= d;
		@(posedge clk_i);
		penable_i <= 1'b1;
		do @(posedge clk_i); while (pready_o !== 1'b1);
		rd_q = prdata_o;
		err_q = pslverr_o;
		psel_i <= 1'b0;
		penable_i <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		check(nm, rd_q, exp);
	endtask
	// polls a field, bounded; reads at least once so stale data never passes
	task automatic poll(input string nm, input logic [7:0] a, input logic [31:0] m,
		input logic [31:0] exp);
		int i;
		i = 0;
		apb(1'b0, a, 32'h0);
		while (i < 100 && (rd_q & m) !== exp) begin
			apb(1'b0, a, 32'h0);
			i++;
		end
		check(nm, rd_q & m, exp);
	endtask
	task automatic chk_rows;
		foreach (rows[i]) begin
			apb(1'b0, rows[i].a, 32'h0);
			check("reg", rd_q, rows[i].v);
			check("slverr", err_q, rows[i].e);
		end
	endtask
	function automatic logic [15:0] crc16(input logic [15:0] c, input logic [7:0] b);
		c = c ^ {8'h00, b};
		for (int i = 0; i < 8; i++) c = c[0] ? (c >> 1) ^ 16'h8408 : c >> 1;
		return c;
	endfunction
	initial begin
		logic [15:0] c;
		int n;
		repeat (4) @(posedge clk_i);
		srst_i <= 1'b0;
		chk_rows();
		// frozen clock enable: a command write must not land
		ce <= 1'b0;
		wr(ADDR_CMD, CMD_RANDOM_ID);
		ce <= 1'b1;
		rd("frozen", ADDR_CMD, CMD_IDLE);
		for (int i = 0; i < BUF_BYTES; i++) wr(ADDR_FIFO, 32'h10 + i);
		wr(ADDR_CMD, CMD_MEM);
		poll("mem", ADDR_CMD, 32'hF, CMD_IDLE);
		rd("mem level", ADDR_LEVEL, 32'h0);
		wr(ADDR_MODE, 32'h0);
		wr(ADDR_CMD, CMD_SOFT_RESET);
		chk_rows();
		wr(ADDR_CMD, CMD_MEM);
		poll("readback", ADDR_CMD, 32'hF, CMD_IDLE);
		for (int i = 0; i < BUF_BYTES; i++) rd("buf", ADDR_FIFO, 32'h10 + i);
		wr(ADDR_CMD, CMD_RANDOM_ID);
		poll("random", ADDR_CMD, 32'hF, CMD_IDLE);
		wr(ADDR_CMD, CMD_MEM);
		poll("readback", ADDR_CMD, 32'hF, CMD_IDLE);
		n = 0;
		for (int i = 0; i < BUF_BYTES; i++) begin
			apb(1'b0, ADDR_FIFO, 32'h0);
			buf_q[i] = rd_q[7:0];
			n += (rd_q !== 32'h10 + i);
		end
		check("random count", n > 0 && n <= RAND_BYTES, 1);
		for (int p = 0; p < 4; p++) begin
			wr(ADDR_CMD, CMD_IDLE);
			wr(ADDR_MODE, 32'h3C | p);
			wr(ADDR_FIFO, 32'h31);
			wr(ADDR_CMD, CMD_CRC_CALC);
			poll("crc drain", ADDR_LEVEL, 32'hFF, 0);
			c = crc16(pre[p], 8'h31);
			rd("crc", ADDR_CRC, {16'h0, c});
		end
		// pause on empty, resume on a late byte
		wr(ADDR_FIFO, 32'h3C);
		poll("crc drain", ADDR_LEVEL, 32'hFF, 0);
		rd("crc", ADDR_CRC, {16'h0, crc16(c, 8'h3C)});
		rd("crc runs", ADDR_CMD, CMD_CRC_CALC);
		wr(ADDR_CMD, 32'h30 | CMD_KEEP);
		rd("keep", ADDR_CMD, 32'h30 | CMD_CRC_CALC);
		check("pd", pd, 1);
		check("rcv off", roff, 1);
		wr(ADDR_CMD, CMD_IDLE);
		wr(ADDR_TEST, SELF_TEST_ON);
		wr(ADDR_CMD, CMD_CRC_CALC);
		poll("self test", ADDR_LEVEL, 32'hFF, SELF_TEST_BYTES);
		wr(ADDR_CMD, CMD_IDLE);
		wr(ADDR_TEST, 32'h0);
		for (int i = 0; i < SELF_TEST_BYTES; i++) apb(1'b0, ADDR_FIFO, 32'h0);
		for (int i = 0; i < 3; i++) wr(ADDR_FIFO, 32'h81 + i);
		n = n_idle;
		wr(ADDR_CMD, CMD_TRANSMIT);
		poll("tx", ADDR_CMD, 32'hF, CMD_IDLE);
		for (int i = 0; i < 3; i++) check("tx", u_rcs_far_model.got[i], 32'h81 + i);
		wr(ADDR_FIFO, 32'h9C);
		wr(ADDR_CMD, CMD_TRANSCEIVE);
		repeat (8) @(posedge clk_i);
		check("trx held", u_rcs_far_model.got.size(), 3);
		check("tx idle irq", n_idle - n, 1);
		wr(ADDR_FRAMING, 32'h80);
		poll("trx sent", ADDR_LEVEL, 32'hFF, 0);
		check("trx", u_rcs_far_model.got[3], 32'h9C);
		u_rcs_far_model.send(8'h44, 1'b1);
		poll("trx rx", ADDR_LEVEL, 32'hFF, 1);
		rd("trx cmd", ADDR_CMD, CMD_TRANSCEIVE);
		rd("trx data", ADDR_FIFO, 32'h44);
		wr(ADDR_CMD, CMD_RECEIVE);
		u_rcs_far_model.send(8'h55, 1'b0);
		u_rcs_far_model.send(8'h66, 1'b1);
		poll("rx", ADDR_CMD, 32'hF, CMD_IDLE);
		rd("rx", ADDR_FIFO, 32'h55);
		rd("rx", ADDR_FIFO, 32'h66);
		wr(ADDR_RXMODE, 32'h4);
		wr(ADDR_CMD, CMD_RECEIVE);
		u_rcs_far_model.send(8'h77, 1'b1);
		rd("multi", ADDR_CMD, CMD_RECEIVE);
		wr(ADDR_CMD, CMD_IDLE);
		wr(ADDR_RXMODE, 32'h0);
		rd("multi", ADDR_FIFO, 32'h77);
		for (int k = 0; k < 2; k++) begin
			u_rcs_far_model.fail = k[0];
			for (int i = 0; i < AUTH_ARGS; i++) wr(ADDR_FIFO, i ? i : 32'h60);
			wr(ADDR_CMD, CMD_CARD_AUTH);
			wr(ADDR_FIFO, 32'hEE);
			poll("auth err", ADDR_ERROR, 32'h81, k ? 32'h81 : 32'h80);
			poll("auth end", ADDR_CMD, 32'hF, CMD_IDLE);
			rd("cipher", ADDR_STATUS, k ? 32'h0 : 32'h8);
			wr(ADDR_ERROR, 32'h81);
			wr(ADDR_CMD, CMD_IDLE);
		end
		// hard reset with the core idle keeps the buffer
		srst_i <= 1'b1;
		hpd <= 1'b1;
		repeat (2) @(posedge clk_i);
		srst_i <= 1'b0;
		hpd <= 1'b0;
		chk_rows();
		wr(ADDR_CMD, CMD_MEM);
		poll("readback", ADDR_CMD, 32'hF, CMD_IDLE);
		for (int i = 0; i < BUF_BYTES; i++) rd("kept", ADDR_FIFO, buf_q[i]);
		conclude();
	end
endmodule
